// ---- hdl/imse_exec.sv ----
// Purpose: executes indirect move, option load, reset, rotate,
//   subtract forms and sleep, issued as commands over Avalon-MM
// Assumes: ref_clk_i 40 MHz, all inputs synchronous
// Notes: every access takes one wait cycle
// Functional notes
// RQ1: the two-bit mode picks pre/post increment/decrement of the pointer.
// RQ2: window accesses reach the data byte at the matching pointer.
// RQ3: the 16-bit pointer wraps both ways.
// RQ4: pointer updates by a move leave all status flags alone.
// RQ5: option load copies the accumulator and touches no flag.
// RQ6: software reset resets the block and clears the reset flag.
// RQ7: rotate right through carry, result routed by the destination bit.
// RQ8: literal minus accumulator lands in the accumulator with flags.
// RQ9: carry and digit carry mean subtrahend not above minuend.
// RQ10: file minus accumulator, result routed by the destination bit.
// RQ11: borrow form also subtracts the inverted carry.
// RQ12: sleep clears the power-down flag and sets the time-out flag.
// RQ13: sleep clears the watchdog and halts until wake.
// RQ14: every subtract sets zero exactly when the result is zero.
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
module imse_exec
  import imse_pkg::*;
#(
  parameter int MEM_DEPTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic wake_i,
  output logic sleep_o,
  output logic watchdog_clear_o,
  output logic soft_reset_o,
  output logic [7:0] option_o
);
  localparam int AW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;
  if (MEM_DEPTH < 2 || MEM_DEPTH > 256 || (1 << AW) != MEM_DEPTH) begin : g_chk
    $error("MEM_DEPTH must be a power of two from 2 to 256");
  end

  function automatic logic [AW-1:0] mem_idx(input logic [15:0] p);
    return p[AW-1:0];
  endfunction : mem_idx

  function automatic logic [15:0] merge16(input logic [15:0] old,
    input logic [31:0] wd, input logic [3:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  imse_bus_state_type bus_state;
  imse_bus_state_type next_bus_state;
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] acc;
  logic [7:0] option;
  logic [15:0] ptr0;
  logic [15:0] ptr1;
  logic c_flag;
  logic dc_flag;
  logic z_flag;
  logic powerdown_flag_n;
  logic timeout_flag_n;
  logic reset_instruction_flag_n;
  logic asleep;

  // bus handshake
  wire req = avs_read_i | avs_write_i;
  wire answer = (bus_state == IMSE_BUS_ANSWER);
  wire wr_take = avs_write_i & answer;
  wire rd_first = avs_read_i & ~answer;
  wire be0 = avs_byteenable_i[0];
  wire [31:0] wd = avs_writedata_i;
  wire hit_cmd = avs_address_i == IMSE_OFS_CMD;
  wire wr_acc = wr_take & be0 & (avs_address_i == IMSE_OFS_ACC);
  wire wr_stat = wr_take & be0 & (avs_address_i == IMSE_OFS_STATUS);
  wire wr_ptr0 = wr_take & (avs_address_i == IMSE_OFS_PTR0);
  wire wr_ptr1 = wr_take & (avs_address_i == IMSE_OFS_PTR1);
  wire wr_opt = wr_take & be0 & (avs_address_i == IMSE_OFS_OPTION);
  wire wr_pwr = wr_take & be0 & (avs_address_i == IMSE_OFS_PWR_CTRL);
  wire wr_win0 = wr_take & be0 & (avs_address_i == IMSE_OFS_WIN0);
  wire wr_win1 = wr_take & be0 & (avs_address_i == IMSE_OFS_WIN1);

  // command decode; halted core ignores commands
  wire exec_go = wr_take & hit_cmd & (&avs_byteenable_i[1:0]) & ~asleep;
  wire [3:0] op = wd[IMSE_CMD_OP_LSB +: 4];
  wire dest = wd[IMSE_CMD_DEST_BIT];
  wire imse_mode_type mode = imse_mode_type'(wd[IMSE_CMD_MODE_LSB +: 2]);
  wire sel = wd[IMSE_CMD_SEL_BIT];
  wire [7:0] arg = wd[IMSE_CMD_ARG_LSB +: 8];
  wire is_move = exec_go & (op == IMSE_OP_MOVE_IND);
  wire is_opt = exec_go & (op == IMSE_OP_OPTION);
  wire do_rst = exec_go & (op == IMSE_OP_RESET);
  wire is_rot = exec_go & (op == IMSE_OP_ROT_RIGHT);
  wire is_lit_sub = exec_go & (op == IMSE_OP_LIT_SUB);
  wire is_file_sub = exec_go & (op == IMSE_OP_FILE_SUB);
  wire is_file_subb = exec_go & (op == IMSE_OP_FILE_SUBB);
  wire is_sleep = exec_go & (op == IMSE_OP_SLEEP);
  wire is_sub = is_lit_sub | is_file_sub | is_file_subb;
  wire file_op = is_rot | is_file_sub | is_file_subb;
  wire to_acc = is_lit_sub | (file_op & ~dest);
  wire to_file = file_op & dest;

  // pointer stepping
  wire [15:0] sel_ptr = sel ? ptr1 : ptr0;
  logic [15:0] eff_ptr;
  logic [15:0] stepped_ptr;
  imse_ptr_step u_ptr (
    .ptr_i(sel_ptr),
    .mode_i(mode),
    .eff_o(eff_ptr),
    .next_o(stepped_ptr)
  );

  // operands
  wire [AW-1:0] f_idx = arg[AW-1:0];
  wire [7:0] f_val = mem[f_idx];
  imse_alu_if alu_bus ();
  // RQ8 literal is the minuend
  assign alu_bus.a = is_lit_sub ? arg : f_val;
  assign alu_bus.b = acc;
  // RQ11 borrow is inverse carry
  assign alu_bus.cin = (is_file_subb | is_rot) ? c_flag : 1'b1;
  assign alu_bus.rotate = is_rot;
  imse_alu u_alu (
    .bus(alu_bus)
  );

  // RQ2 window goes to pointed byte
  wire [AW-1:0] win0_idx = mem_idx(ptr0);
  wire [AW-1:0] win1_idx = mem_idx(ptr1);
  // data memory write port
  wire mem_we = is_move | to_file | wr_win0 | wr_win1;
  wire [AW-1:0] mem_wa = is_move ? mem_idx(eff_ptr) :
    to_file ? f_idx : wr_win0 ? win0_idx : win1_idx;
  // RQ10 result back to file register
  wire [7:0] mem_wd = is_move ? acc : to_file ? alu_bus.res : wd[7:0];

  // next values
  // RQ6 software reset wins over everything
  wire [7:0] next_acc = do_rst ? IMSE_RST_ACC :
    to_acc ? alu_bus.res : wr_acc ? wd[7:0] : acc;
  // RQ5 option load from accumulator
  wire [7:0] next_option = do_rst ? IMSE_RST_OPTION :
    is_opt ? acc : wr_opt ? wd[7:0] : option;
  // RQ1 pointer update after move
  wire [15:0] next_ptr0 = do_rst ? IMSE_RST_PTR :
    (is_move & ~sel) ? stepped_ptr :
    wr_ptr0 ? merge16(ptr0, wd, avs_byteenable_i) : ptr0;
  wire [15:0] next_ptr1 = do_rst ? IMSE_RST_PTR :
    (is_move & sel) ? stepped_ptr :
    wr_ptr1 ? merge16(ptr1, wd, avs_byteenable_i) : ptr1;
  // RQ4 flags change only on alu ops, status register writes and software reset
  wire next_c = do_rst ? 1'b0 : (is_sub | is_rot) ? alu_bus.c :
    wr_stat ? wd[IMSE_ST_C] : c_flag;
  // RQ9 digit carry from low nibble
  wire next_dc = do_rst ? 1'b0 : is_sub ? alu_bus.dc :
    wr_stat ? wd[IMSE_ST_DC] : dc_flag;
  // RQ14 zero only from subtracts, status register writes and software reset
  wire next_z = do_rst ? 1'b0 : is_sub ? alu_bus.z :
    wr_stat ? wd[IMSE_ST_Z] : z_flag;
  // RQ12 sleep flag effects
  wire next_powerdown_n = do_rst | (powerdown_flag_n & ~is_sleep);
  wire next_timeout_n = do_rst | is_sleep | timeout_flag_n;
  // RQ6 reset cause flag cleared
  wire next_ri_n = ~do_rst & (wr_pwr ? wd[0] : reset_instruction_flag_n);
  // RQ13 halt until wake
  wire next_asleep = ~do_rst & (is_sleep | (asleep & ~wake_i));

  wire [31:0] rd_mux =
    (avs_address_i == IMSE_OFS_ACC) ? {24'h000000, acc} :
    (avs_address_i == IMSE_OFS_STATUS) ? {27'h0000000, timeout_flag_n,
      powerdown_flag_n, z_flag, dc_flag, c_flag} :
    (avs_address_i == IMSE_OFS_PTR0) ? {16'h0000, ptr0} :
    (avs_address_i == IMSE_OFS_PTR1) ? {16'h0000, ptr1} :
    (avs_address_i == IMSE_OFS_OPTION) ? {24'h000000, option} :
    (avs_address_i == IMSE_OFS_PWR_CTRL) ?
      {31'h00000000, reset_instruction_flag_n} :
    (avs_address_i == IMSE_OFS_WIN0) ? {24'h000000, mem[win0_idx]} :
    (avs_address_i == IMSE_OFS_WIN1) ? {24'h000000, mem[win1_idx]} :
    32'h00000000;

  always_comb begin
    unique case (bus_state)
      IMSE_BUS_IDLE: next_bus_state = req ? IMSE_BUS_ANSWER : IMSE_BUS_IDLE;
      IMSE_BUS_ANSWER: next_bus_state = IMSE_BUS_IDLE;
      default: next_bus_state = IMSE_BUS_IDLE;
    endcase
  end

  // one wait cycle lets read data come from a flop
  assign avs_waitrequest_o = req & ~answer;
  assign sleep_o = asleep;
  assign option_o = option;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_state <= IMSE_BUS_IDLE;
      avs_readdata_o <= 32'h00000000;
    end else begin
      bus_state <= next_bus_state;
      if (rd_first) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc <= IMSE_RST_ACC;
      option <= IMSE_RST_OPTION;
      ptr0 <= IMSE_RST_PTR;
      ptr1 <= IMSE_RST_PTR;
      {c_flag, dc_flag, z_flag} <= 3'h0;
      {powerdown_flag_n, timeout_flag_n} <= 2'h3;
      reset_instruction_flag_n <= 1'b1;
      asleep <= 1'b0;
      watchdog_clear_o <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      acc <= next_acc;
      option <= next_option;
      ptr0 <= next_ptr0;
      ptr1 <= next_ptr1;
      {c_flag, dc_flag, z_flag} <= {next_c, next_dc, next_z};
      {powerdown_flag_n, timeout_flag_n} <= {next_powerdown_n, next_timeout_n};
      reset_instruction_flag_n <= next_ri_n;
      asleep <= next_asleep;
      // RQ13 watchdog clear pulse
      watchdog_clear_o <= is_sleep;
      soft_reset_o <= do_rst;
    end
  end

  // data bytes keep their value over a software reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  pre_inc_wrap_a: assert property ( // RQ3
    is_move && !sel && mode == IMSE_PRE_INC |=>
      ptr0 == $past(ptr0) + 16'h0001 && mem[mem_idx(ptr0)] == $past(acc))
    else $error("pre-increment move wrong");
  post_dec_a: assert property ( // RQ1
    is_move && sel && mode == IMSE_POST_DEC |=>
      ptr1 == $past(ptr1) - 16'h0001
      && mem[mem_idx($past(ptr1))] == $past(acc))
    else $error("post-decrement move wrong");
  window_read_a: assert property ( // RQ2
    avs_read_i && answer && avs_address_i == IMSE_OFS_WIN0 |->
      avs_readdata_o == {24'h000000, mem[win0_idx]})
    else $error("window read not redirected");
  window1_read_a: assert property ( // RQ2
    avs_read_i && answer && avs_address_i == IMSE_OFS_WIN1 |->
      avs_readdata_o == {24'h000000, mem[win1_idx]})
    else $error("second window read not redirected");
  move_flags_a: assert property ( // RQ4
    is_move |=> $stable({c_flag, dc_flag, z_flag}))
    else $error("move changed flags");
  option_load_a: assert property ( // RQ5
    is_opt |=> option_o == $past(acc) && $stable({c_flag, dc_flag, z_flag}))
    else $error("option load wrong");
  soft_reset_a: assert property ( // RQ6
    do_rst |=> !reset_instruction_flag_n && soft_reset_o && acc == 8'h00)
    else $error("software reset wrong");
  rotate_acc_a: assert property ( // RQ7
    is_rot && !dest |=> acc == {$past(c_flag), $past(f_val[7:1])}
      && c_flag == $past(f_val[0]))
    else $error("rotate wrong");
  literal_sub_a: assert property ( // RQ8
    is_lit_sub |=> acc == 8'($past(arg) - $past(acc))
      && c_flag == ($past(acc) <= $past(arg))
      && dc_flag == ($past(acc[3:0]) <= $past(arg[3:0])))
    else $error("literal subtract wrong");
  file_sub_a: assert property ( // RQ10
    is_file_sub && dest |=>
      mem[$past(f_idx)] == 8'($past(f_val) - $past(acc))
      && acc == $past(acc))
    else $error("file subtract wrong");
  borrow_sub_a: assert property ( // RQ11
    is_file_subb && !dest |=>
      acc == 8'($past(f_val) - $past(acc) - {7'h00, ~$past(c_flag)}))
    else $error("borrow subtract wrong");
  sub_zero_a: assert property ( // RQ14
    is_sub && !dest |=> z_flag == (acc == 8'h00))
    else $error("zero flag wrong");
  sleep_flags_a: assert property ( // RQ12
    is_sleep |=> !powerdown_flag_n && timeout_flag_n && sleep_o)
    else $error("sleep flags wrong");
  sleep_watchdog_a: assert property ( // RQ13
    is_sleep |=> watchdog_clear_o ##1 !watchdog_clear_o)
    else $error("watchdog clear pulse wrong");

  cover_sub_c: cover property (is_file_subb ##[1:30] is_file_subb);
  cover_sleep_c: cover property (is_sleep ##[1:50] !sleep_o);
  cover_move_c: cover property (is_move && ptr0 == 16'hFFFF);
  cover_file_c: cover property (is_file_sub && dest);
  cover_reset_c: cover property (do_rst);
endmodule : imse_exec

// ---- include/imse_pkg.sv ----
// Purpose: shared constants for the indirect move / subtract executor
// Assumes: byte addresses on an Avalon-MM slave, 32-bit data
// Notes: 8-bit registers sit in the low byte, upper bits read zero
package imse_pkg;
  localparam logic [7:0] IMSE_OFS_CMD = 8'h00;
  localparam logic [7:0] IMSE_OFS_ACC = 8'h04;
  localparam logic [7:0] IMSE_OFS_STATUS = 8'h08;
  localparam logic [7:0] IMSE_OFS_PTR0 = 8'h0C;
  localparam logic [7:0] IMSE_OFS_PTR1 = 8'h10;
  localparam logic [7:0] IMSE_OFS_OPTION = 8'h14;
  localparam logic [7:0] IMSE_OFS_PWR_CTRL = 8'h18;
  localparam logic [7:0] IMSE_OFS_WIN0 = 8'h1C;
  localparam logic [7:0] IMSE_OFS_WIN1 = 8'h20;
  // command word layout
  localparam int IMSE_CMD_OP_LSB = 0;
  localparam int IMSE_CMD_DEST_BIT = 4;
  localparam int IMSE_CMD_MODE_LSB = 5;
  localparam int IMSE_CMD_SEL_BIT = 7;
  localparam int IMSE_CMD_ARG_LSB = 8;
  localparam logic [3:0] IMSE_OP_MOVE_IND = 4'h1;
  localparam logic [3:0] IMSE_OP_OPTION = 4'h2;
  localparam logic [3:0] IMSE_OP_RESET = 4'h3;
  localparam logic [3:0] IMSE_OP_ROT_RIGHT = 4'h4;
  localparam logic [3:0] IMSE_OP_LIT_SUB = 4'h5;
  localparam logic [3:0] IMSE_OP_FILE_SUB = 4'h6;
  localparam logic [3:0] IMSE_OP_FILE_SUBB = 4'h7;
  localparam logic [3:0] IMSE_OP_SLEEP = 4'h8;
  // status register bit positions
  localparam int IMSE_ST_C = 0;
  localparam int IMSE_ST_DC = 1;
  localparam int IMSE_ST_Z = 2;
  localparam int IMSE_ST_PWRDN = 3;
  localparam int IMSE_ST_TIMEOUT = 4;
  // values after reset, and the pointer step
  localparam logic [7:0] IMSE_RST_ACC = 8'h00;
  localparam logic [7:0] IMSE_RST_OPTION = 8'hFF;
  localparam logic [15:0] IMSE_RST_PTR = 16'h0000;
  localparam logic [15:0] IMSE_PTR_STEP = 16'h0001;
  typedef enum logic [1:0] {
    IMSE_PRE_INC = 2'h0,
    IMSE_PRE_DEC = 2'h1,
    IMSE_POST_INC = 2'h2,
    IMSE_POST_DEC = 2'h3
  } imse_mode_type;
  typedef enum logic [1:0] {
    IMSE_BUS_IDLE = 2'b01,
    IMSE_BUS_ANSWER = 2'b10
  } imse_bus_state_type;
endpackage : imse_pkg

// ---- include/imse_alu_if.sv ----
// Purpose: operand and result bundle between executor and its alu
// Assumes: purely combinational path
// Notes: rotate selects the carry rotate instead of subtraction
interface imse_alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic rotate;
  logic [7:0] res;
  logic c;
  logic dc;
  logic z;
  modport core (output a, output b, output cin, output rotate,
    input res, input c, input dc, input z);
  modport alu (input a, input b, input cin, input rotate,
    output res, output c, output dc, output z);
endinterface : imse_alu_if

// ---- hdl/imse_alu.sv ----
// Purpose: subtract a - b with carry-in, or rotate a right through carry
// Assumes: cin is 1 for plain subtract, carry flag for borrow forms
// Notes: carry means no borrow, as in two's complement addition
module imse_alu
  import imse_pkg::*;
(
  imse_alu_if.alu bus
);
  logic [8:0] sum;
  logic [4:0] nib;
  // RQ9 carry as no-borrow
  assign sum = {1'b0, bus.a} + {1'b0, ~bus.b} + {8'h00, bus.cin};
  assign nib = {1'b0, bus.a[3:0]} + {1'b0, ~bus.b[3:0]} + {4'h0, bus.cin};
  // RQ7 rotate through carry
  assign bus.res = bus.rotate ? {bus.cin, bus.a[7:1]} : sum[7:0];
  assign bus.c = bus.rotate ? bus.a[0] : sum[8];
  assign bus.dc = nib[4];
  // RQ14 zero from result
  assign bus.z = (bus.res == 8'h00);
endmodule : imse_alu

// ---- hdl/imse_ptr_step.sv ----
// Purpose: effective address and updated pointer for indirect moves
// Assumes: 16-bit pointer
// Notes: wrap comes free from 16-bit arithmetic
module imse_ptr_step
  import imse_pkg::*;
(
  input wire logic [15:0] ptr_i,
  input wire imse_mode_type mode_i,
  output logic [15:0] eff_o,
  output logic [15:0] next_o
);
  logic dec;
  logic pre;
  logic [15:0] moved;
  assign dec = (mode_i == IMSE_PRE_DEC) || (mode_i == IMSE_POST_DEC);
  assign pre = (mode_i == IMSE_PRE_INC) || (mode_i == IMSE_PRE_DEC);
  // RQ3 modulo wrap
  assign moved = dec ? ptr_i - IMSE_PTR_STEP : ptr_i + IMSE_PTR_STEP;
  // RQ1 pre before, post after
  assign eff_o = pre ? moved : ptr_i;
  assign next_o = moved;
endmodule : imse_ptr_step

// ---- test/imse_master.sv ----
// Purpose: avalon-mm master standing in for the instruction sequencer
// Assumes: slave answers by lowering waitrequest, any number of cycles
// Notes: waitrequest and read data are taken at the accepting rising edge
module imse_master (
  input wire logic clk_i,
  input wire logic waitrequest_i,
  input wire logic [31:0] readdata_i,
  output logic [7:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  output logic [3:0] byteenable_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    address_o = 8'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0;
    byteenable_o = 4'h0;
  end

  task automatic xfer(input logic rd, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    address_o <= a;
    writedata_o <= d;
    byteenable_o <= 4'hF;
    read_o <= rd;
    write_o <= !rd;
    // values read here are those the slave saw at this edge
    do begin
      @(posedge clk_i);
    end while (waitrequest_i !== 1'b0);
    q = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
    // idle data is not left looking valid
    writedata_o <= ~d;
  endtask : xfer
endmodule : imse_master

// ---- test/imse_exec_tb.sv ----
// Purpose: self-checking bench for the indirect move / subtract executor
// Assumes: one access at a time through the master model
// Notes: file operands live in data byte 5, reached through window 1
module imse_exec_tb;
  import imse_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk_i;
  logic rst_n_i;
  logic wake_i;
  logic [7:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  logic sleep_o;
  logic watchdog_clear_o;
  logic soft_reset_o;
  logic [7:0] option_o;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  imse_exec #(.MEM_DEPTH(16)) imse_exec_inst (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .avs_address_i(address), .avs_read_i(read),
    .avs_write_i(write), .avs_writedata_i(writedata),
    .avs_byteenable_i(byteenable), .avs_readdata_o(readdata),
    .avs_waitrequest_o(waitrequest), .wake_i(wake_i), .sleep_o(sleep_o),
    .watchdog_clear_o(watchdog_clear_o), .soft_reset_o(soft_reset_o),
    .option_o(option_o));

  imse_master imse_master_inst (.clk_i(ref_clk_i),
    .waitrequest_i(waitrequest), .readdata_i(readdata),
    .address_o(address), .read_o(read), .write_o(write),
    .writedata_o(writedata), .byteenable_o(byteenable));

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic results;
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // hang guard, about eight times the expected run
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    imse_master_inst.xfer(1'b0, a, d, q);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    logic [31:0] q;
    imse_master_inst.xfer(1'b1, a, 32'h0, q);
    chk(nm, q, e);
  endtask : rd_chk

  function automatic logic [31:0] cmd(input logic [3:0] op,
    input logic dest, input logic [1:0] mode, input logic [7:0] arg);
    return {16'h0, arg, 1'b0, mode, dest, op};
  endfunction : cmd

  task automatic t_reset;
    rd_chk("status", IMSE_OFS_STATUS, 32'h18);
    rd_chk("power_control", IMSE_OFS_PWR_CTRL, 32'h1);
    rd_chk("option", IMSE_OFS_OPTION, 32'hFF);
    chk("option_o", {24'h0, option_o}, 32'hFF);
    wr(8'h40, 32'hA5);
    rd_chk("unmapped", 8'h40, 32'h0);
  endtask : t_reset

  task automatic t_move;
    logic [1:0] md [4];
    logic [15:0] ef [4];
    logic [15:0] pt [4];
    md = '{2'h1, 2'h0, 2'h2, 2'h3};
    ef = '{16'hFFFF, 16'h0000, 16'h0000, 16'h0001};
    pt = '{16'hFFFF, 16'h0000, 16'h0001, 16'h0000};
    wr(IMSE_OFS_STATUS, 32'h7);
    wr(IMSE_OFS_PTR0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(IMSE_OFS_ACC, 32'(8'h11 * (i + 1)));
      wr(IMSE_OFS_CMD, cmd(IMSE_OP_MOVE_IND, 1'b0, md[i], 8'h00));
      rd_chk("ptr", IMSE_OFS_PTR0, {16'h0, pt[i]});
      wr(IMSE_OFS_PTR1, {16'h0, ef[i]});
      rd_chk("win", IMSE_OFS_WIN1, 32'(8'h11 * (i + 1)));
      rd_chk("flags", IMSE_OFS_STATUS, 32'h1F);
    end
    // pointer 1 post-decrement, read back through window 0
    wr(IMSE_OFS_PTR1, 32'h3);
    wr(IMSE_OFS_ACC, 32'h55);
    wr(IMSE_OFS_CMD, cmd(IMSE_OP_MOVE_IND, 1'b0, 2'h3, 8'h00)
      | (32'h1 << IMSE_CMD_SEL_BIT));
    rd_chk("ptr1", IMSE_OFS_PTR1, 32'h2);
    wr(IMSE_OFS_PTR0, 32'h3);
    rd_chk("win0", IMSE_OFS_WIN0, 32'h55);
  endtask : t_move

  task automatic t_option;
    wr(IMSE_OFS_ACC, 32'h3C);
    wr(IMSE_OFS_CMD, cmd(IMSE_OP_OPTION, 1'b0, 2'h0, 8'h00));
    // let the accepting edge settle before looking
    #1;
    chk("option_o", {24'h0, option_o}, 32'h3C);
    rd_chk("option", IMSE_OFS_OPTION, 32'h3C);
    rd_chk("flags", IMSE_OFS_STATUS, 32'h1F);
  endtask : t_option

  task automatic sub_one(input logic [3:0] op, input logic [7:0] a,
    input logic [7:0] b, input logic cin, input logic dest);
    logic [7:0] r;
    logic bw;
    logic cy;
    logic dcy;
    // only the borrow form borrows, by the inverted carry
    bw = (op == IMSE_OP_FILE_SUBB) ? !cin : 1'b0;
    r = a - b - {7'h00, bw};
    cy = {1'b0, a} >= {1'b0, b} + {8'h00, bw};
    dcy = {1'b0, a[3:0]} >= {1'b0, b[3:0]} + {4'h0, bw};
    wr(IMSE_OFS_STATUS, {31'h0, cin});
    wr(IMSE_OFS_ACC, {24'h0, b});
    wr(IMSE_OFS_PTR1, 32'h5);
    wr(IMSE_OFS_WIN1, {24'h0, a});
    wr(IMSE_OFS_CMD, cmd(op, dest, 2'h0,
      (op == IMSE_OP_LIT_SUB) ? a : 8'h05));
    rd_chk("acc", IMSE_OFS_ACC, {24'h0, dest ? b : r});
    rd_chk("file", IMSE_OFS_WIN1, {24'h0, dest ? r : a});
    rd_chk("flags", IMSE_OFS_STATUS,
      32'h18 | {29'h0, r == 8'h00, dcy, cy});
  endtask : sub_one

  task automatic t_sub;
    sub_one(IMSE_OP_LIT_SUB, 8'h10, 8'h01, 1'b0, 1'b0);
    sub_one(IMSE_OP_LIT_SUB, 8'h05, 8'h05, 1'b0, 1'b0);
    sub_one(IMSE_OP_LIT_SUB, 8'h02, 8'h03, 1'b1, 1'b0);
    sub_one(IMSE_OP_FILE_SUB, 8'h80, 8'h01, 1'b0, 1'b1);
    sub_one(IMSE_OP_FILE_SUB, 8'h33, 8'h33, 1'b0, 1'b0);
    sub_one(IMSE_OP_FILE_SUBB, 8'h10, 8'h0F, 1'b0, 1'b0);
    sub_one(IMSE_OP_FILE_SUBB, 8'h10, 8'h0F, 1'b1, 1'b1);
    sub_one(IMSE_OP_FILE_SUBB, 8'h00, 8'h00, 1'b0, 1'b0);
  endtask : t_sub

  task automatic t_rrf;
    wr(IMSE_OFS_STATUS, 32'h6);
    wr(IMSE_OFS_PTR1, 32'h5);
    wr(IMSE_OFS_WIN1, 32'h03);
    wr(IMSE_OFS_CMD, cmd(IMSE_OP_ROT_RIGHT, 1'b0, 2'h0, 8'h05));
    rd_chk("acc", IMSE_OFS_ACC, 32'h01);
    rd_chk("file", IMSE_OFS_WIN1, 32'h03);
    rd_chk("flags", IMSE_OFS_STATUS, 32'h1F);
    wr(IMSE_OFS_CMD, cmd(IMSE_OP_ROT_RIGHT, 1'b1, 2'h0, 8'h05));
    rd_chk("file", IMSE_OFS_WIN1, 32'h81);
    rd_chk("flags", IMSE_OFS_STATUS, 32'h1F);
  endtask : t_rrf

  task automatic t_sleep;
    wr(IMSE_OFS_STATUS, 32'h0);
    wr(IMSE_OFS_CMD, cmd(IMSE_OP_SLEEP, 1'b0, 2'h0, 8'h00));
    #1;
    chk("watchdog_clear", {31'h0, watchdog_clear_o}, 32'h1);
    chk("sleep", {31'h0, sleep_o}, 32'h1);
    @(posedge ref_clk_i);
    #1;
    chk("watchdog_clear", {31'h0, watchdog_clear_o}, 32'h0);
    rd_chk("status", IMSE_OFS_STATUS, 32'h10);
    wr(IMSE_OFS_ACC, 32'h12);
    wr(IMSE_OFS_CMD, cmd(IMSE_OP_LIT_SUB, 1'b0, 2'h0, 8'h20));
    rd_chk("acc", IMSE_OFS_ACC, 32'h12);
    @(posedge ref_clk_i);
    wake_i <= 1'b1;
    @(posedge ref_clk_i);
    wake_i <= 1'b0;
    #1;
    chk("sleep", {31'h0, sleep_o}, 32'h0);
  endtask : t_sleep

  task automatic t_swreset;
    wr(IMSE_OFS_ACC, 32'h77);
    wr(IMSE_OFS_CMD, cmd(IMSE_OP_RESET, 1'b0, 2'h0, 8'h00));
    #1;
    chk("soft_reset", {31'h0, soft_reset_o}, 32'h1);
    rd_chk("power_control", IMSE_OFS_PWR_CTRL, 32'h0);
    rd_chk("acc", IMSE_OFS_ACC, 32'h0);
    rd_chk("option", IMSE_OFS_OPTION, 32'hFF);
    wr(IMSE_OFS_PWR_CTRL, 32'h1);
    rd_chk("power_control", IMSE_OFS_PWR_CTRL, 32'h1);
  endtask : t_swreset

  initial begin
    rst_n_i = 1'b0;
    wake_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_move();
    t_option();
    t_sub();
    t_rrf();
    t_sleep();
    t_swreset();
    results();
  end
endmodule : imse_exec_tb
